// ==== logic/dmx_pkg.sv ====
// Constants for the data-memory decode and expanded-RAM controller.
// Assumes a 32-bit AHB-Lite register bus; register offsets are indexes, bytes = 4 * index.
`default_nettype none
package dmx_pkg;
  // Register indexes and byte addresses
  localparam logic [31:0] DMX_IDX_AUX      = 32'h0000008E;
  localparam logic [31:0] DMX_IDX_PSC      = 32'h000000A2;
  localparam logic [31:0] DMX_IDX_STRETCH  = 32'h000000C0;
  localparam logic [31:0] DMX_IDX_POINTER  = 32'h000000C1;
  localparam logic [31:0] DMX_IDX_STATUS   = 32'h000000C2;
  localparam logic [31:0] DMX_ADDR_AUX     = DMX_IDX_AUX * 32'h4;
  localparam logic [31:0] DMX_ADDR_PSC     = DMX_IDX_PSC * 32'h4;
  localparam logic [31:0] DMX_ADDR_STRETCH = DMX_IDX_STRETCH * 32'h4;
  localparam logic [31:0] DMX_ADDR_POINTER = DMX_IDX_POINTER * 32'h4;
  localparam logic [31:0] DMX_ADDR_STATUS  = DMX_IDX_STATUS * 32'h4;
  // Field positions
  localparam int DMX_AUX_MODE_BIT  = 0;  // latch_strobe_mode
  localparam int DMX_AUX_EXT_BIT   = 1;  // external_data_select
  localparam int DMX_AUX_SIZE_BIT  = 2;  // internal_size_select
  localparam int DMX_PSC_SEL_BIT   = 0;  // pointer_select
  localparam int DMX_PSC_ZERO_BIT  = 2;  // stuck at zero
  localparam int DMX_PSC_FLAG_BIT  = 3;  // general_flag
  localparam int DMX_STR_BIT       = 0;  // strobe_stretch
  localparam int DMX_STAT_BUSY_BIT = 0;
  localparam int DMX_STAT_EXT_BIT  = 1;
  // Reset values
  localparam logic DMX_RST_MODE    = 1'b0;
  localparam logic DMX_RST_EXT     = 1'b0;
  localparam logic DMX_RST_SIZE    = 1'b0;
  localparam logic DMX_RST_SEL     = 1'b0;
  localparam logic DMX_RST_FLAG    = 1'b0;
  localparam logic DMX_RST_STRETCH = 1'b0;
  localparam logic [15:0] DMX_RST_POINTER = 16'h0000;
  // Memory map of the core data side
  localparam logic [7:0]  DMX_LOWER_TOP  = 8'h7F;
  localparam logic [15:0] DMX_EXPANDED_RAM_TOP_S = 16'h00FF;
  localparam logic [15:0] DMX_EXPANDED_RAM_TOP_L = 16'h01FF;
  localparam int DMX_IRAM_BYTES = 256;
  localparam int DMX_EXPANDED_RAM_BYTES = 512;
  // Timing, in clock periods of clk_sys
  localparam logic [4:0] DMX_STROBE_SHORT = 5'd6;
  localparam logic [4:0] DMX_STROBE_LONG  = 5'd30;
  localparam logic [2:0] DMX_ALE_PERIOD   = 3'd6;

  typedef enum logic [1:0] {DMX_X_IDLE, DMX_X_ADDR, DMX_X_STRB} dmx_xstate_e;
endpackage : dmx_pkg
`default_nettype wire

// ==== logic/dmx_data_mem.sv ====
// Data-memory decode, expanded RAM, external multiplexed bus and dual data pointers.
// Assumes one core clock, synchronous active-high reset, a single AHB-Lite master,
// and an external memory that answers within the strobe pulse on port zero.
`timescale 1ns/100ps
`default_nettype none

module dmx_data_mem
  import dmx_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Core internal data port
  input  wire logic        core_req,
  input  wire logic        core_direct,
  input  wire logic        core_stack,
  input  wire logic [7:0]  core_addr,
  input  wire logic        core_we,
  input  wire logic [7:0]  core_wdata,
  output logic             core_ack,
  output logic [7:0]       core_rdata,
  output logic             sfr_req,
  output logic [7:0]       sfr_addr,
  output logic             sfr_we,
  output logic [7:0]       sfr_wdata,
  // Core expanded-RAM move port
  input  wire logic        ext_move_req,
  input  wire logic        ext_move_via_pointer,
  input  wire logic [7:0]  ext_move_reg_addr,
  input  wire logic        ext_move_we,
  input  wire logic [7:0]  ext_move_wdata,
  input  wire logic        pointer_inc,
  output logic             ext_move_ready,
  output logic             ext_move_done,
  output logic [7:0]       ext_move_rdata,
  output logic             pointer_select,
  // External multiplexed bus
  input  wire logic [7:0]  port_zero_in,
  output logic [7:0]       port_zero_out,
  output logic             port_zero_oe,
  output logic [7:0]       port_two_out,
  output logic             port_two_oe,
  output logic             latch_strobe,
  output logic             read_strobe_n,
  output logic             write_strobe_n
);

  typedef struct packed {
    logic [DMX_IRAM_BYTES-1:0][7:0] iram;
    logic [DMX_EXPANDED_RAM_BYTES-1:0][7:0] expanded_ram;
    logic                           mode;
    logic                           ext;
    logic                           size;
    logic                           stretch;
    logic                           sel;
    logic                           flag;
    logic [1:0][15:0]               ptr;
    logic                           dwait;
    logic                           dwrite;
    logic [31:0]                    daddr;
    logic [31:0]                    rdata;
    logic                           ack;
    logic [7:0]                     crdata;
    logic                           sreq;
    logic [7:0]                     saddr;
    logic                           swe;
    logic [7:0]                     swdata;
    dmx_xstate_e                    xst;
    logic [4:0]                     xcnt;
    logic                           xlong;
    logic                           xwe;
    logic                           xlast_ext;
    logic                           xdone;
    logic [7:0]                     xrdata;
    logic [7:0]                     p0;
    logic                           p0_oe;
    logic [7:0]                     p2;
    logic                           p2_oe;
    logic                           ale;
    logic [2:0]                     ale_cnt;
    logic                           rd_n;
    logic                           wr_n;
  } dmx_state_s;

  dmx_state_s cur;
  dmx_state_s next_cur;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when an expanded address falls inside internal expanded RAM
  function automatic logic expanded_ram_hit(input logic ext, input logic size, input logic [15:0] a);
    expanded_ram_hit = !ext && (a <= (size ? DMX_EXPANDED_RAM_TOP_L : DMX_EXPANDED_RAM_TOP_S));
  endfunction : expanded_ram_hit

  function automatic logic [31:0] reg_read(input logic [31:0] a, input dmx_state_s s);
    logic [31:0] v;
    v = 32'h00000000;
    if (a == DMX_ADDR_AUX) begin
      v[DMX_AUX_MODE_BIT] = s.mode;
      v[DMX_AUX_EXT_BIT]  = s.ext;
      v[DMX_AUX_SIZE_BIT] = s.size;
    end else if (a == DMX_ADDR_PSC) begin
      v[DMX_PSC_SEL_BIT]  = s.sel;
      v[DMX_PSC_FLAG_BIT] = s.flag;
      v[DMX_PSC_ZERO_BIT] = 1'b0;
    end else if (a == DMX_ADDR_STRETCH) begin
      v[DMX_STR_BIT] = s.stretch;
    end else if (a == DMX_ADDR_POINTER) begin
      v[15:0] = s.ptr[s.sel];
    end else if (a == DMX_ADDR_STATUS) begin
      v[DMX_STAT_BUSY_BIT] = (s.xst != DMX_X_IDLE);
      v[DMX_STAT_EXT_BIT]  = s.xlast_ext;
    end
    reg_read = v;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [15:0] move_addr;
  logic        move_int;
  logic        to_sfr;

  always_comb begin
    next_cur = cur;
    next_cur.ack   = 1'b0;
    next_cur.sreq  = 1'b0;
    next_cur.xdone = 1'b0;

    // Free-running divider for the latch strobe
    next_cur.ale_cnt = (cur.ale_cnt == DMX_ALE_PERIOD - 3'd1) ? 3'd0 : cur.ale_cnt + 3'd1;

    // Data pointer increment from the core
    if (pointer_inc) begin
      next_cur.ptr[cur.sel] = cur.ptr[cur.sel] + 16'h0001;
    end

    // Bus: one wait cycle, then the data phase completes
    if (cur.dwait) begin
      next_cur.dwait = 1'b0;
      next_cur.rdata = reg_read(cur.daddr, cur);
      if (cur.dwrite) begin
        if (cur.daddr == DMX_ADDR_AUX) begin
          next_cur.mode = hwdata[DMX_AUX_MODE_BIT];
          next_cur.ext  = hwdata[DMX_AUX_EXT_BIT];
          next_cur.size = hwdata[DMX_AUX_SIZE_BIT];
        end else if (cur.daddr == DMX_ADDR_PSC) begin
          // An increment is just a write of read+1; bit 2 reads zero so carry stops there
          next_cur.sel  = hwdata[DMX_PSC_SEL_BIT];
          next_cur.flag = hwdata[DMX_PSC_FLAG_BIT];
        end else if (cur.daddr == DMX_ADDR_STRETCH) begin
          next_cur.stretch = hwdata[DMX_STR_BIT];
        end else if (cur.daddr == DMX_ADDR_POINTER) begin
          next_cur.ptr[cur.sel] = hwdata[15:0];
        end
      end
    end
    if (hsel && htrans[1] && hready) begin
      next_cur.dwait  = 1'b1;
      next_cur.dwrite = hwrite;
      next_cur.daddr  = haddr;
    end

    // Core internal data: addressing mode picks the space above 7Fh
    to_sfr = core_direct && !core_stack && (core_addr > DMX_LOWER_TOP);
    if (core_req) begin
      if (to_sfr) begin
        next_cur.sreq   = 1'b1;
        next_cur.saddr  = core_addr;
        next_cur.swe    = core_we;
        next_cur.swdata = core_wdata;
      end else begin
        next_cur.ack    = 1'b1;
        next_cur.crdata = cur.iram[core_addr];
        if (core_we) begin
          next_cur.iram[core_addr] = core_wdata;
        end
      end
    end

    // Expanded RAM moves
    move_addr = ext_move_via_pointer ? cur.ptr[cur.sel] : {8'h00, ext_move_reg_addr};
    move_int  = expanded_ram_hit(cur.ext, cur.size, move_addr);
    next_cur.ale = (cur.mode == DMX_RST_MODE) && (next_cur.ale_cnt == 3'd0);
    case (cur.xst)
      DMX_X_IDLE: begin
        if (ext_move_req) begin
          next_cur.xlast_ext = !move_int;
          if (move_int) begin
            // Ports and strobes are left alone
            next_cur.xdone  = 1'b1;
            next_cur.xrdata = cur.expanded_ram[move_addr[8:0]];
            if (ext_move_we) begin
              next_cur.expanded_ram[move_addr[8:0]] = ext_move_wdata;
            end
          end else begin
            next_cur.xst   = DMX_X_ADDR;
            next_cur.xwe   = ext_move_we;
            next_cur.xlong = cur.stretch;
            next_cur.p0    = move_addr[7:0];
            next_cur.p0_oe = 1'b1;
            next_cur.ale   = 1'b1;
            if (ext_move_via_pointer) begin
              next_cur.p2    = move_addr[15:8];
              next_cur.p2_oe = 1'b1;
            end
            next_cur.swdata = cur.swdata;
            next_cur.xrdata = ext_move_wdata;
          end
        end
      end
      DMX_X_ADDR: begin
        next_cur.xst   = DMX_X_STRB;
        next_cur.ale   = 1'b0;
        next_cur.xcnt  = (cur.xlong ? DMX_STROBE_LONG : DMX_STROBE_SHORT) - 5'd1;
        next_cur.rd_n  = cur.xwe;
        next_cur.wr_n  = !cur.xwe;
        next_cur.p0    = cur.xrdata;
        next_cur.p0_oe = cur.xwe;
      end
      default: begin
        next_cur.ale = 1'b0;
        if (cur.xcnt == 5'd0) begin
          next_cur.xst   = DMX_X_IDLE;
          next_cur.rd_n  = 1'b1;
          next_cur.wr_n  = 1'b1;
          next_cur.p0_oe = 1'b0;
          next_cur.p2_oe = 1'b0;
          next_cur.xdone = 1'b1;
          if (!cur.xwe) begin
            next_cur.xrdata = port_zero_in;
          end
        end else begin
          next_cur.xcnt = cur.xcnt - 5'd1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur         <= '0;
      cur.mode    <= DMX_RST_MODE;
      cur.ext     <= DMX_RST_EXT;
      cur.size    <= DMX_RST_SIZE;
      cur.stretch <= DMX_RST_STRETCH;
      cur.sel     <= DMX_RST_SEL;
      cur.flag    <= DMX_RST_FLAG;
      cur.ptr     <= {DMX_RST_POINTER, DMX_RST_POINTER};
      cur.xst     <= DMX_X_IDLE;
      cur.rd_n    <= 1'b1;
      cur.wr_n    <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign hreadyout      = !cur.dwait;
  assign hresp          = 1'b0;
  assign hrdata         = cur.rdata;
  assign core_ack       = cur.ack;
  assign core_rdata     = cur.crdata;
  assign sfr_req        = cur.sreq;
  assign sfr_addr       = cur.saddr;
  assign sfr_we         = cur.swe;
  assign sfr_wdata      = cur.swdata;
  assign ext_move_ready = (cur.xst == DMX_X_IDLE);
  assign ext_move_done  = cur.xdone;
  assign ext_move_rdata = cur.xrdata;
  assign pointer_select = cur.sel;
  assign port_zero_out  = cur.p0;
  assign port_zero_oe   = cur.p0_oe;
  assign port_two_out   = cur.p2;
  assign port_two_oe    = cur.p2_oe;
  assign latch_strobe   = cur.ale;
  assign read_strobe_n  = cur.rd_n;
  assign write_strobe_n = cur.wr_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Counts cycles a strobe has been low, for the pulse-width checks
  logic [5:0] rd_low;
  logic [5:0] wr_low;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_low <= 6'd0;
      wr_low <= 6'd0;
    end else begin
      rd_low <= cur.rd_n ? 6'd0 : rd_low + 6'd1;
      wr_low <= cur.wr_n ? 6'd0 : wr_low + 6'd1;
    end
  end

  default clocking dmx_cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_read_pulse_len: assert property ($rose(read_strobe_n) |->
    rd_low == {1'b0, (cur.xlong ? DMX_STROBE_LONG : DMX_STROBE_SHORT)})
    else $error("read strobe width wrong");
  a_write_pulse_len: assert property ($rose(write_strobe_n) |->
    wr_low == {1'b0, (cur.xlong ? DMX_STROBE_LONG : DMX_STROBE_SHORT)})
    else $error("write strobe width wrong");
  a_internal_quiet: assert property (
    ext_move_ready && ext_move_req && move_int |=>
    ext_move_done && read_strobe_n && write_strobe_n && !port_zero_oe && !port_two_oe)
    else $error("internal expanded access disturbed the bus");
  a_ext_goes_out: assert property (
    ext_move_ready && ext_move_req && cur.ext |=> latch_strobe && port_zero_oe ##1
    (!read_strobe_n || !write_strobe_n))
    else $error("external select did not reach the bus");
  a_ptr_addr_out: assert property (
    ext_move_ready && ext_move_req && ext_move_via_pointer && !move_int |=>
    port_two_oe && port_two_out == $past(cur.ptr[cur.sel][15:8])
    && port_zero_out == $past(cur.ptr[cur.sel][7:0]))
    else $error("pointer address not on ports");
  a_reg_p2_idle: assert property (
    ext_move_ready && ext_move_req && !ext_move_via_pointer |=> !port_two_oe)
    else $error("register move drove port two");
  a_direct_sfr: assert property (
    core_req && core_direct && !core_stack && core_addr[7] |=> sfr_req && !core_ack)
    else $error("direct upper access missed special registers");
  a_indirect_ram: assert property (
    core_req && (!core_direct || core_stack) |=> core_ack && !sfr_req)
    else $error("indirect or stack access left internal RAM");
  a_ale_quiet: assert property (
    cur.mode && ext_move_ready && !(ext_move_req && !move_int) |=> !latch_strobe)
    else $error("latch strobe pulsed outside a move");
  a_psc_bit2_zero: assert property (
    cur.dwait && cur.daddr == DMX_ADDR_PSC |=> !hrdata[2])
    else $error("select register bit 2 read as one");

  c_ext_read: cover property ($rose(read_strobe_n));
  c_ext_write_long: cover property ($rose(write_strobe_n) && cur.xlong);
  c_sfr_access: cover property (sfr_req);
  c_ptr_toggle: cover property ($changed(pointer_select));

endmodule : dmx_data_mem
`default_nettype wire

// ==== dv/dmx_ext_mem.sv ====
// Behavioural external data memory on the multiplexed port-zero and port-two bus.
// Assumes the controller's bus outputs; lag sets how many strobe cycles pass before data.
`timescale 1ns/100ps
`default_nettype none
module dmx_ext_mem (
  input  wire logic       clk_sys,
  input  wire logic [7:0] port_zero_out,
  input  wire logic       port_zero_oe,
  input  wire logic [7:0] port_two_out,
  input  wire logic       port_two_oe,
  input  wire logic       latch_strobe,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [2:0] lag,
  output logic      [7:0] port_zero_in
);
  logic [7:0]  mem [0:65535] = '{default: 8'h00};
  logic [15:0] addr = 16'h0000;
  logic [7:0]  junk = 8'h00;
  int          n    = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    // No port two drive means a paged address; page zero stands in for the port pins
    if (latch_strobe && port_zero_oe) begin
      addr <= {port_two_oe ? port_two_out : 8'h00, port_zero_out};
    end
    n <= read_strobe_n ? 0 : n + 1;
    junk <= junk + 8'h3B;
    if (!write_strobe_n) begin
      mem[addr] <= port_zero_out;
    end
  end
  // Outside the strobe the bus shows a moving pattern, so a stale sample cannot pass
  assign port_zero_in = (!read_strobe_n && n >= int'(lag)) ? mem[addr] : junk;
endmodule : dmx_ext_mem
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the data-memory decode and expanded-RAM controller.
// Assumes the external memory model on the far side and word-only AHB-Lite access.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dmx_pkg::*;
  logic        clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        core_req, core_direct, core_stack, core_we, core_ack, sfr_req, sfr_we;
  logic        ext_move_req, ext_move_via_pointer, ext_move_we, pointer_inc;
  logic        ext_move_ready, ext_move_done, pointer_select;
  logic        port_zero_oe, port_two_oe, latch_strobe, read_strobe_n, write_strobe_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, lag;
  logic [7:0]  core_addr, core_wdata, core_rdata, sfr_addr, sfr_wdata;
  logic [7:0]  ext_move_reg_addr, ext_move_wdata, ext_move_rdata;
  logic [7:0]  port_zero_in, port_zero_out, port_two_out;
  int          iram [256];
  int          xr [512];
  int          em [int];
  int          ptr [2];
  logic [31:0] reset_addr [6] = '{DMX_ADDR_AUX, DMX_ADDR_PSC, DMX_ADDR_STRETCH,
                                  DMX_ADDR_POINTER, DMX_ADDR_STATUS, 32'h400};
  int          sel, flag, ext, size, strl, mismatches, n_compared, cnt, rs;
  assign hready = hreadyout;
  dmx_data_mem dut (.*);
  dmx_ext_mem partner (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int n;
    n = 0;
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
    do @(posedge clk_sys); while (hready !== 1'b1 && ++n < 50);
    {htrans, hwdata} <= {2'b00, d};
    do @(posedge clk_sys); while (hready !== 1'b1 && ++n < 100);
    // Select stays up between transfers; an idle htrans already means no transfer
    r = hrdata;
    chk(hready, 32'h1, "bus ready");
    chk(hresp, 32'h0, "response");
  endtask : ahb
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp, "register read");
  endtask : rd
  task automatic setcfg(input int m, e, s, st);
    wr(DMX_ADDR_AUX, (m << DMX_AUX_MODE_BIT) | (e << DMX_AUX_EXT_BIT) | (s << DMX_AUX_SIZE_BIT));
    wr(DMX_ADDR_STRETCH, st << DMX_STR_BIT);
    {ext, size, strl} = {e, s, st};
  endtask : setcfg
  task automatic setp(input int v);
    wr(DMX_ADDR_POINTER, v);
    ptr[sel] = v;
  endtask : setp
  task automatic inc_psc;
    logic [31:0] r;
    ahb(1'b0, DMX_ADDR_PSC, 32'h0, r);
    chk(r, (flag << DMX_PSC_FLAG_BIT) | sel, "select read");
    ahb(1'b1, DMX_ADDR_PSC, r + 32'h1, r);
    sel ^= 1;
    chk(pointer_select, sel, "select toggled");
  endtask : inc_psc
  task automatic core(input logic dir, stk, input logic [7:0] a, input logic we,
                      input logic [7:0] d);
    {core_req, core_direct, core_stack, core_addr, core_we, core_wdata} <= {1'b1, dir, stk, a, we, d};
    @(posedge clk_sys);
    core_req <= 1'b0;
    @(posedge clk_sys);
    if (dir && !stk && a > DMX_LOWER_TOP) begin
      chk({sfr_req, core_ack, sfr_addr, sfr_we, sfr_wdata}, {2'b10, a, we, d}, "sfr route");
    end else begin
      chk({sfr_req, core_ack, core_rdata}, {2'b01, iram[a][7:0]}, "ram route");
      if (we) iram[a] = d;
    end
  endtask : core
  task automatic xm(input logic vp, input logic [7:0] ra, input logic we, input logic [7:0] d);
    int a, ex, nr, nw, n0, n2, n, k, len;
    a = vp ? ptr[sel] : ra;
    ex = ext || (vp && a > (size ? 511 : 255));
    len = strl ? 30 : 6;
    {ext_move_req, ext_move_via_pointer, ext_move_we, ext_move_reg_addr, ext_move_wdata} <= {1'b1, vp, we, ra, d};
    n = 0;
    do @(posedge clk_sys); while (ext_move_ready !== 1'b1 && ++n < 50);
    ext_move_req <= 1'b0;
    {nr, nw, n0, n2, k} = '0;
    do begin
      @(posedge clk_sys);
      k++;
      nr += (read_strobe_n === 1'b0);
      nw += (write_strobe_n === 1'b0);
      n0 += (port_zero_oe === 1'b1);
      n2 += (port_two_oe === 1'b1);
      if (port_two_oe === 1'b1) chk(port_two_out, a[15:8], "high byte");
      if (k == 1 && ex) chk({latch_strobe, port_zero_oe, port_zero_out}, {2'b11, a[7:0]}, "low byte");
    end while (ext_move_done !== 1'b1 && ++n < 100);
    chk(ext_move_done, 32'h1, "move done");
    chk(nr, (ex != 0 && !we) ? len : 0, "read strobe length");
    chk(nw, (ex != 0 && we) ? len : 0, "write strobe length");
    chk({n0 > 0, n2 > 0}, {ex != 0, ex && vp}, "port drive");
    if (we && ex) em[a] = d;
    else if (we) xr[a] = d;
    else chk(ext_move_rdata, ex ? (em.exists(a) ? em[a] : 0) : xr[a], "move read");
    rd(DMX_ADDR_STATUS, (ex != 0) ? (32'h1 << DMX_STAT_EXT_BIT) : 32'h0);
  endtask : xm
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    test_done;
  end
  initial begin
    {rst, hsel, hwrite, haddr, hwdata, htrans, hsize} = {1'b1, 68'h0, 3'b010};
    {core_req, core_direct, core_stack, core_addr, core_we, core_wdata} = '0;
    {ext_move_req, ext_move_via_pointer, ext_move_reg_addr, ext_move_we, ext_move_wdata} = '0;
    {pointer_inc, lag} = '0;
    {sel, flag, ext, size, strl, mismatches, n_compared} = '0;
    rs = $urandom(91357);
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, and an unmapped word that must read zero
    foreach (reset_addr[i]) begin
      rd(reset_addr[i], 0);
    end
    core(1'b1, 1'b0, 8'h7F, 1'b1, 8'h3C);
    core(1'b1, 1'b0, 8'h80, 1'b1, 8'hC3);
    core(1'b1, 1'b1, 8'h80, 1'b0, 8'h00);
    repeat (60) core($urandom_range(0, 1), $urandom_range(0, 1), $urandom, $urandom_range(0, 1), $urandom);
    cnt = 0;
    repeat (60) begin
      @(posedge clk_sys);
      cnt += (latch_strobe === 1'b1);
    end
    chk(cnt, 10, "free-run latch");
    setcfg(1, 0, 0, 0);
    cnt = 0;
    repeat (30) begin
      @(posedge clk_sys);
      cnt += (latch_strobe === 1'b1);
    end
    chk(cnt, 0, "quiet latch");
    // Pointer pair: each select keeps its own value, increments only toggle
    setp(16'h1234);
    inc_psc();
    setp(16'hBEEF);
    pointer_inc <= 1'b1;
    @(posedge clk_sys);
    pointer_inc <= 1'b0;
    ptr[sel] = ptr[sel] + 1;
    inc_psc();
    rd(DMX_ADDR_POINTER, 32'h1234);
    inc_psc();
    rd(DMX_ADDR_POINTER, 32'hBEF0);
    wr(DMX_ADDR_PSC, 32'hFF);
    {sel, flag} = {1, 1};
    inc_psc();
    // Mixed moves over a small address set so reads meet earlier writes
    repeat (80) begin
      setcfg($urandom_range(0, 1), $urandom_range(0, 1), $urandom_range(0, 1), $urandom_range(0, 1));
      lag <= $urandom_range(0, 5);
      if ($urandom_range(0, 1)) inc_psc();
      setp({$urandom_range(0, 3), 8'h5A});
      xm($urandom_range(0, 1), $urandom_range(0, 1) ? 8'h5A : 8'hA5, $urandom_range(0, 1), $urandom);
    end
    test_done;
  end
endmodule : testbench
`default_nettype wire
